// File: adcsq_top.sv
`timescale 1ns/10ps
`default_nettype none
module adcsq_top import adcsq_pkg::*; #(
  parameter int CAL_CYCLES = ADCSQ_CAL_CYC  // shorten in simulation
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // analog core
  output logic [4:0]       ana_chan_o,
  output logic             ana_port_sel_o,
  output logic             ana_sample_o,
  output logic             ana_convert_o,
  input  wire logic [9:0]  ana_data_i,
  // digital view of analog pins
  input  wire logic [23:0] dig_pins_i,
  // interrupt and transfer request
  output logic             irq_o,
  output logic             xfer_req_o
);

  //----------------------------------------------------------
  // declarations
  //----------------------------------------------------------
  adcsq_state_t      state_q;        // sequencer state
  logic [15:0]       ctrl_q;         // control register
  logic [7:0]        stim_q;         // sample time
  logic [7:0]        ctim_q;         // conversion time
  logic              psel_q;         // extra port select
  logic [15:0]       cal_q;          // calibration counter
  logic [7:0]        cnt_q;          // phase counter
  logic [4:0]        cur_q;          // current scan channel
  logic [4:0]        inj_ch_q;       // injected channel
  logic              inj_pend_q;     // injection requested
  logic              inj_act_q;      // injection converting
  logic [14:0]       res_q;          // result: chan + value
  logic [14:0]       tmp_q;          // held result buffer
  logic [14:0]       ires_q;         // injection result
  logic              unread_q;       // result not yet read
  logic [2:0]        irqs_q;         // sticky status
  logic [2:0]        imsk_q;         // interrupt mask
  logic [2:0]        irq_set;        // status set events
  logic [31:0]       rdata_q;        // registered read data
  logic              xfer_q;         // transfer request
  logic              wr_acc;         // write access phase
  logic              rd_acc;         // read access phase
  logic              setup;          // setup phase
  logic              mapped;         // address decodes
  logic              start_w;        // start write pulse
  logic              inj_w;          // injection write pulse
  logic              res_rd;         // result read
  logic              conv_end;       // conversion finishing
  logic              go_hold;        // store must wait
  logic              more;           // another conversion due
  logic [4:0]        nxt_ch;         // next channel
  logic [14:0]       new_res;        // fresh result word
  logic [1:0]        mode;           // conversion mode
  logic              cont;           // continuous mode
  logic              scan;           // auto scan mode
  logic [4:0]        sel_ch;         // programmed channel

  //----------------------------------------------------------
  // apb decode
  //----------------------------------------------------------
  assign setup  = psel_i & ~penable_i;
  assign wr_acc = psel_i & penable_i & pwrite_i & mapped;
  assign rd_acc = psel_i & penable_i & ~pwrite_i & mapped;
  // no wait states; data is registered in setup phase
  // reading in the setup phase costs nothing on the bus and
  // keeps prdata_o off any combinational path from the core
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;
  assign prdata_o  = rdata_q;

  assign mode   = ctrl_q[ADCSQ_MODE_LSB +: 2];
  assign cont   = mode[0];
  assign scan   = mode[1];
  assign sel_ch = ctrl_q[ADCSQ_CHAN_LSB +: 5];

  // address map check
  always_comb begin
    case (paddr_i)
      ADCSQ_CTRL_OFS, ADCSQ_TIME_OFS, ADCSQ_RES_OFS,
      ADCSQ_INJ_OFS, ADCSQ_PSEL_OFS, ADCSQ_STAT_OFS,
      ADCSQ_IRQS_OFS, ADCSQ_IMSK_OFS,
      ADCSQ_DIN_OFS: mapped = 1'b1;
      default:       mapped = 1'b0;
    endcase
  end

  // write and read strobes that act rather than store
  assign start_w = wr_acc & (paddr_i == ADCSQ_CTRL_OFS)
                 & pwdata_i[ADCSQ_START_BIT];
  assign inj_w   = wr_acc & (paddr_i == ADCSQ_CTRL_OFS)
                 & pwdata_i[ADCSQ_INJ_BIT];
  assign res_rd  = rd_acc & (paddr_i == ADCSQ_RES_OFS);

  //----------------------------------------------------------
  // read data register
  //----------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (setup) begin
      case (paddr_i)
        ADCSQ_CTRL_OFS: rdata_q <= {16'h0000, ctrl_q};
        ADCSQ_TIME_OFS: rdata_q <= {16'h0000, ctim_q, stim_q};
        ADCSQ_RES_OFS:  rdata_q <= {17'h00000, res_q};
        ADCSQ_INJ_OFS:  rdata_q <= {17'h00000, ires_q};
        ADCSQ_PSEL_OFS: rdata_q <= {31'h0, psel_q};
        // busy covers calibration too
        ADCSQ_STAT_OFS: rdata_q <= {29'h0, inj_pend_q, unread_q,
                                    state_q != ADCSQ_IDLE};
        ADCSQ_IRQS_OFS: rdata_q <= {29'h0, irqs_q};
        ADCSQ_IMSK_OFS: rdata_q <= {29'h0, imsk_q};
        ADCSQ_DIN_OFS:  rdata_q <= {8'h00, dig_pins_i};
        default:        rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  //----------------------------------------------------------
  // software configuration registers
  //----------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= ADCSQ_CTRL_RST;
      stim_q <= ADCSQ_STIM_RST;
      ctim_q <= ADCSQ_CTIM_RST;
      psel_q <= 1'b0;
      imsk_q <= 3'h0;
    end else if (wr_acc) begin
      case (paddr_i)
        // pulse bits are not stored
        ADCSQ_CTRL_OFS: begin
          ctrl_q <= pwdata_i[15:0]
                  & ~(16'h0001 << ADCSQ_START_BIT)
                  & ~(16'h0001 << ADCSQ_INJ_BIT);
        end
        ADCSQ_TIME_OFS: begin
          stim_q <= pwdata_i[ADCSQ_STIM_LSB +: 8];
          ctim_q <= pwdata_i[ADCSQ_CTIM_LSB +: 8];
        end
        ADCSQ_PSEL_OFS: psel_q <= pwdata_i[0];
        ADCSQ_IMSK_OFS: imsk_q <= pwdata_i[2:0];
        default: ;
      endcase
    end
  end

  //----------------------------------------------------------
  // sequencing decisions
  //----------------------------------------------------------
  assign conv_end = (state_q == ADCSQ_CONV) && (cnt_q == 8'h00);
  assign new_res  = {ana_chan_o, ana_data_i};
  // a store must wait if the old value is unread and either
  // wait-for-read (continuous) or suspend protection is on
  assign go_hold = unread_q & ((ctrl_q[ADCSQ_WAIT_BIT] & cont)
                 | ctrl_q[ADCSQ_SUSP_BIT]);

  // next channel after a normal store
  always_comb begin
    more   = 1'b0;
    nxt_ch = cur_q;
    if (scan) begin
      if (cur_q != 5'h00) begin
        more   = 1'b1;
        nxt_ch = cur_q - 5'h01;
      end else begin
        more   = cont;
        nxt_ch = sel_ch;
      end
    end else begin
      more = cont;
    end
  end

  //----------------------------------------------------------
  // calibration counter
  //----------------------------------------------------------
  // counts down once after each reset; width fits 40630
  // a small simulation value of CAL_CYCLES only starts the
  // counter lower; the sequence after it is the same
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cal_q <= 16'(CAL_CYCLES - 1);
    end else if (state_q == ADCSQ_CAL && cal_q != 16'h0000) begin
      cal_q <= cal_q - 16'h0001;
    end
  end

  //----------------------------------------------------------
  // main sequencer
  //----------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_q   <= ADCSQ_CAL;
      cnt_q     <= 8'h00;
      cur_q     <= 5'h00;
      inj_act_q <= 1'b0;
    end else begin
      case (state_q)
        // starts are ignored until calibration ends
        ADCSQ_CAL: begin
          if (cal_q == 16'h0000) begin
            state_q <= ADCSQ_IDLE;
          end
        end
        ADCSQ_IDLE: begin
          if (start_w) begin
            // take new mode and channel from the same write
            state_q <= ADCSQ_SAMP;
            cnt_q   <= stim_q;
            cur_q   <= pwdata_i[ADCSQ_CHAN_LSB +: 5];
          end
        end
        ADCSQ_SAMP: begin
          if (cnt_q == 8'h00) begin
            state_q <= ADCSQ_CONV;
            cnt_q   <= ctim_q;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        ADCSQ_CONV: begin
          if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (inj_act_q) begin
            // resume the running mode on its own channel
            inj_act_q <= 1'b0;
            state_q   <= ADCSQ_SAMP;
            cnt_q     <= stim_q;
          end else if (go_hold) begin
            state_q <= ADCSQ_HOLD;
          end else if (more) begin
            cur_q   <= nxt_ch;
            state_q <= ADCSQ_SAMP;
            cnt_q   <= stim_q;
            // injection slots in before the next normal one
            if (inj_pend_q) begin
              inj_act_q <= 1'b1;
            end
          end else begin
            state_q <= ADCSQ_IDLE;
          end
        end
        // the fresh value waits in tmp_q; nothing converts until
        // software reads the old result, so no value is lost
        ADCSQ_HOLD: begin
          if (res_rd) begin
            // held value moves up; continue or stop
            if (more) begin
              cur_q   <= nxt_ch;
              state_q <= ADCSQ_SAMP;
              cnt_q   <= stim_q;
            end else begin
              state_q <= ADCSQ_IDLE;
            end
          end
        end
        default: state_q <= ADCSQ_IDLE;
      endcase
    end
  end

  //----------------------------------------------------------
  // injection request
  //----------------------------------------------------------
  // only honoured while a continuous mode is running
  // a second inject before the first is served only moves the
  // channel; one injected conversion is done, not two
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      inj_pend_q <= 1'b0;
      inj_ch_q   <= 5'h00;
    end else if (inj_w && cont && state_q != ADCSQ_IDLE
                 && state_q != ADCSQ_CAL) begin
      inj_pend_q <= 1'b1;
      inj_ch_q   <= pwdata_i[ADCSQ_ICH_LSB +: 5];
    end else if (conv_end && !inj_act_q && !go_hold && more) begin
      inj_pend_q <= 1'b0;
    end
  end

  //----------------------------------------------------------
  // result registers and unread flag
  //----------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      res_q    <= 15'h0000;
      tmp_q    <= 15'h0000;
      ires_q   <= 15'h0000;
      unread_q <= 1'b0;
    end else begin
      if (conv_end && inj_act_q) begin
        ires_q <= new_res;
      end else if (conv_end && go_hold) begin
        tmp_q <= new_res;
      end else if (conv_end) begin
        res_q    <= new_res;
        unread_q <= 1'b1;
      end else if (state_q == ADCSQ_HOLD && res_rd) begin
        res_q    <= tmp_q;          // held value is now unread
        unread_q <= 1'b1;
      end else if (res_rd) begin
        unread_q <= 1'b0;
      end
    end
  end

  //----------------------------------------------------------
  // interrupts and transfer request
  //----------------------------------------------------------
  always_comb begin
    irq_set = 3'h0;
    irq_set[ADCSQ_IRQ_DONE] = conv_end & ~inj_act_q & ~go_hold
      | (state_q == ADCSQ_HOLD) & res_rd;
    // overwrite of an unread value when not holding
    irq_set[ADCSQ_IRQ_OVR]  = conv_end & ~inj_act_q & ~go_hold
                            & unread_q;
    irq_set[ADCSQ_IRQ_INJ]  = conv_end & inj_act_q;
  end

  // set wins over a write-one clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < ADCSQ_NIRQ; gi++) begin : g_irq
      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          irqs_q[gi] <= 1'b0;
        end else if (irq_set[gi]) begin
          irqs_q[gi] <= 1'b1;
        end else if (wr_acc && paddr_i == ADCSQ_IRQS_OFS
                     && pwdata_i[gi]) begin
          irqs_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq_o = |(irqs_q & imsk_q);

  // one pulse per value stored in res_q for the transfer unit
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      xfer_q <= 1'b0;
    end else begin
      xfer_q <= irq_set[ADCSQ_IRQ_DONE];
    end
  end
  assign xfer_req_o = xfer_q;

  //----------------------------------------------------------
  // analog core drive
  //----------------------------------------------------------
  // channels 16..23 come from the port chosen by psel
  // sample and convert are plain state decodes, so they change
  // on the same edge as the sequencer and never overlap
  assign ana_chan_o     = inj_act_q ? inj_ch_q : cur_q;
  assign ana_port_sel_o = psel_q;
  assign ana_sample_o   = (state_q == ADCSQ_SAMP);
  assign ana_convert_o  = (state_q == ADCSQ_CONV);

endmodule // adcsq_top
`default_nettype wire

// File: adcsq_pkg.sv
//------------------------------------------------------------
// adcsq_pkg: constants for the converter sequencer
//------------------------------------------------------------
// Summary of operation
// - ten-bit result, 16+8 channels, one sampler
// - one bit picks the extra channel port
// - sample and conversion times software programmable
// - self-calibration runs after every reset
// - busy flag set during calibration
// - no conversion starts while calibrating
// - unread result: overrun request or suspend
// - suspended conversion held until result read
// - single channel single: convert once, store
// - single channel continuous: repeat, store each
// - scan single: each channel once, store each
// - scan continuous: cycle channels, store each
// - each value stored in the result register raises a request
// - wait-for-read (continuous modes only) buffers value, holds conversion
// - injected conversion stores in second register
// - continuous mode resumes after injection
// - unused analog pins readable as digital
package adcsq_pkg;
  // register byte offsets
  localparam logic [7:0] ADCSQ_CTRL_OFS  = 8'h00;
  localparam logic [7:0] ADCSQ_TIME_OFS  = 8'h04;
  localparam logic [7:0] ADCSQ_RES_OFS   = 8'h08;
  localparam logic [7:0] ADCSQ_INJ_OFS   = 8'h0c;
  localparam logic [7:0] ADCSQ_PSEL_OFS  = 8'h10;
  localparam logic [7:0] ADCSQ_STAT_OFS  = 8'h14;
  localparam logic [7:0] ADCSQ_IRQS_OFS  = 8'h18;
  localparam logic [7:0] ADCSQ_IMSK_OFS  = 8'h1c;
  localparam logic [7:0] ADCSQ_DIN_OFS   = 8'h20;
  // control register fields
  localparam int ADCSQ_MODE_LSB  = 0;  // 2 bits
  localparam int ADCSQ_START_BIT = 2;  // write-only pulse
  localparam int ADCSQ_WAIT_BIT  = 3;
  localparam int ADCSQ_CHAN_LSB  = 4;  // 5 bits
  localparam int ADCSQ_INJ_BIT   = 9;  // write-only pulse
  localparam int ADCSQ_ICH_LSB   = 10; // 5 bits
  localparam int ADCSQ_SUSP_BIT  = 15;
  // timing register fields
  localparam int ADCSQ_STIM_LSB  = 0;  // 8 bits
  localparam int ADCSQ_CTIM_LSB  = 8;  // 8 bits
  // reset values
  localparam logic [15:0] ADCSQ_CTRL_RST = 16'h0000;
  localparam logic [7:0]  ADCSQ_STIM_RST = 8'h10;
  localparam logic [7:0]  ADCSQ_CTIM_RST = 8'h20;
  // interrupt status bits
  localparam int ADCSQ_IRQ_DONE = 0;
  localparam int ADCSQ_IRQ_OVR  = 1;
  localparam int ADCSQ_IRQ_INJ  = 2;
  localparam int ADCSQ_NIRQ     = 3;
  // sizes
  localparam int ADCSQ_RES_W  = 10;
  localparam int ADCSQ_NCH    = 24;
  localparam int ADCSQ_NMAIN  = 16;
  // calibration time in cpu clock cycles
  localparam int ADCSQ_CAL_CYC = 40630;
  // sequencer states
  typedef enum logic [2:0] {
    ADCSQ_CAL, ADCSQ_IDLE, ADCSQ_SAMP, ADCSQ_CONV, ADCSQ_HOLD
  } adcsq_state_t;
endpackage

// File: adcsq_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module adcsq_monitor import adcsq_pkg::*; #(
  parameter int CAL_CYCLES = ADCSQ_CAL_CYC  // same count as the design
) (
  // watched ports
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [4:0]  ana_chan_o,
  input wire logic        ana_port_sel_o,
  input wire logic        ana_sample_o,
  input wire logic        ana_convert_o,
  input wire logic [23:0] dig_pins_i,
  input wire logic        irq_o,
  input wire logic        xfer_req_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic [31:0] cal_q;  // cycles since reset, saturates at the calibration length
  // counter kept apart from the design so a short calibration is caught
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cal_q <= 32'h0;
    end else if (cal_q < 32'(CAL_CYCLES)) begin
      cal_q <= cal_q + 32'h1;
    end
  end
  cal_quiet_a: assert property ((cal_q < 32'(CAL_CYCLES)) |->
    !ana_sample_o && !ana_convert_o && !xfer_req_o && !irq_o)
    else $error("activity in calibration");
  one_phase_a: assert property (!(ana_sample_o && ana_convert_o))
    else $error("sample and convert together");
  chan_range_a: assert property (ana_chan_o < 5'h18)
    else $error("channel out of range");
  samp_to_conv_a: assert property ($fell(ana_sample_o) |-> ana_convert_o)
    else $error("sample not followed by convert");
  conv_cause_a: assert property ($rose(ana_convert_o) |-> $past(ana_sample_o))
    else $error("convert without sample");
  xfer_pulse_a: assert property (xfer_req_o |=> !xfer_req_o)
    else $error("transfer request longer than one cycle");
  port_sel_a: assert property (
    (psel_i && penable_i && pwrite_i && paddr_i == ADCSQ_PSEL_OFS)
    |=> ana_port_sel_o == $past(pwdata_i[0])) else $error("port select not taken");
  din_read_a: assert property (
    (psel_i && !penable_i && !pwrite_i && paddr_i == ADCSQ_DIN_OFS)
    |=> prdata_o == {8'h00, $past(dig_pins_i)}) else $error("digital pins misread");
  bad_addr_a: assert property ((psel_i && penable_i && paddr_i > ADCSQ_DIN_OFS
    && paddr_i[1:0] == 2'b00) |-> pslverr_o && pready_o) else $error("unmapped not refused");
  // main scenarios reached
  cover property ($rose(xfer_req_o));
  cover property ($rose(irq_o));
  cover property (pslverr_o);
endmodule  // adcsq_monitor
bind adcsq_top adcsq_monitor #(.CAL_CYCLES(CAL_CYCLES)) i_adcsq_monitor (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .ana_chan_o(ana_chan_o),
  .ana_port_sel_o(ana_port_sel_o), .ana_sample_o(ana_sample_o),
  .ana_convert_o(ana_convert_o), .dig_pins_i(dig_pins_i), .irq_o(irq_o),
  .xfer_req_o(xfer_req_o));
`default_nettype wire

// File: adcsq_ana_model.sv
`timescale 1ns/10ps
`default_nettype none
module adcsq_ana_model (
  // from the sequencer
  input wire logic       mclk_i,
  input wire logic [4:0] chan_i,
  input wire logic       port_i,
  input wire logic       conv_i,
  // converter value
  output logic [9:0]     data_o
);
  logic [9:0] junk_q = 10'h2aa;  // changes every cycle outside conversion
  // a stale value must not look like a good result
  always_ff @(posedge mclk_i) begin
    junk_q <= ~junk_q ^ 10'h155;
  end
  // ten-bit code tells channel and port group apart
  assign data_o = conv_i ? {port_i, chan_i, 4'h5} : junk_q;
endmodule  // adcsq_ana_model
`default_nettype wire

// File: adcsq_tb.sv
`timescale 1ns/10ps
`default_nettype none
module testbench import adcsq_pkg::*;;
  localparam int CAL = 20;  // short calibration
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, perr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q, prdata;
  logic pready, pslverr, psel_o, samp, conv, irq, xfer;
  logic [4:0] chan;
  logic [9:0] adata;
  logic [23:0] pins = 24'ha5c3e1;
  int err_count = 0, n_checks = 0, cyc = 0, xcnt = 0, scnt = 0, ccnt = 0, slen = 0, clen = 0;
  int t0, x0;
  logic [31:0] hcfg [2] = '{32'h3d, 32'h8017};  // wait-for-read, then suspend
  logic [4:0] hc1 [2] = '{5'd3, 5'd1};
  logic [4:0] hc2 [2] = '{5'd3, 5'd0};
  adcsq_top #(.CAL_CYCLES(CAL)) i_adcsq_top (.mclk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .ana_chan_o(chan),
    .ana_port_sel_o(psel_o), .ana_sample_o(samp), .ana_convert_o(conv), .ana_data_i(adata),
    .dig_pins_i(pins), .irq_o(irq), .xfer_req_o(xfer));
  adcsq_ana_model i_adcsq_ana_model (.mclk_i(clk), .chan_i(chan), .port_i(psel_o),
    .conv_i(conv), .data_o(adata));
  initial begin
    forever #10 clk = ~clk;
  end
  // cycle count, pulse count, phase lengths, hang guard
  always @(posedge clk) begin
    cyc++;
    if (xfer === 1'b1) xcnt++;
    if (samp === 1'b1) begin
      scnt++;
    end else if (scnt > 0) begin
      slen = scnt;
      scnt = 0;
    end
    if (conv === 1'b1) begin
      ccnt++;
    end else if (ccnt > 0) begin
      clen = ccnt;
      ccnt = 0;
    end
    if (cyc > 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // one apb transfer, answer taken at the edge where pready is high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // wait states are allowed; only the bench timeout ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    apb(1'b0, a, 32'h0);
    while (q[b] !== v && n < 100) begin
      apb(1'b0, a, 32'h0);
      n++;
    end
    chk("poll", {31'h0, v}, {31'h0, q[b]});
  endtask
  task automatic wait_x();
    int n, c0;
    n = 0;
    c0 = xcnt;
    while (xcnt == c0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("xfer_seen", 32'h1, {31'h0, n < 300});
  endtask
  task automatic get_res(input logic [4:0] c, input logic p);
    wait_x();
    apb(1'b0, ADCSQ_RES_OFS, 32'h0);
    chk("result", {17'h0, c, p, c, 4'h5}, q);
  endtask
  // reset, calibration, then short sample and conversion times
  task automatic rst();
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t0 = cyc;
    apb(1'b0, ADCSQ_TIME_OFS, 32'h0);
    chk("time_rst", 32'h2010, q);
    apb(1'b1, ADCSQ_CTRL_OFS, 32'h4);  // start too early, must be ignored
    apb(1'b0, ADCSQ_STAT_OFS, 32'h0);
    chk("busy", 32'h1, {31'h0, q[0]});
    poll(ADCSQ_STAT_OFS, 0, 1'b0);
    chk("cal_len", 32'h1, {31'h0, (cyc - t0) >= CAL});
    apb(1'b0, ADCSQ_IRQS_OFS, 32'h0);
    chk("no_conv", 32'h0, q);
    apb(1'b1, ADCSQ_TIME_OFS, 32'h0302);
  endtask
  task report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    rst();
    apb(1'b0, ADCSQ_DIN_OFS, 32'h0);
    chk("din", {8'h00, pins}, q);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped", 32'h1, {31'h0, perr});
    $display("test setup done");
    // single channel once on the second port group, with interrupt
    apb(1'b1, ADCSQ_PSEL_OFS, 32'h1);
    apb(1'b1, ADCSQ_IMSK_OFS, 32'h1);
    apb(1'b1, ADCSQ_CTRL_OFS, 32'h54);
    get_res(5'd5, 1'b1);
    chk("samp_len", 32'd3, slen);
    chk("conv_len", 32'd4, clen);
    apb(1'b0, ADCSQ_IRQS_OFS, 32'h0);
    chk("irqs", 32'h1, q);
    chk("irq_on", 32'h1, {31'h0, irq});
    apb(1'b1, ADCSQ_IRQS_OFS, 32'h1);
    apb(1'b0, ADCSQ_IRQS_OFS, 32'h0);
    chk("irq_off", 32'h0, {31'h0, irq});
    x0 = xcnt;
    repeat (40) @(posedge clk);
    chk("once", x0, xcnt);
    $display("test single done");
    // scan once from channel 2 down
    rst();
    apb(1'b1, ADCSQ_CTRL_OFS, 32'h26);
    for (int c = 2; c >= 0; c--) get_res(5'(c), 1'b0);
    x0 = xcnt;
    repeat (40) @(posedge clk);
    chk("scan_once", x0, xcnt);
    $display("test scan done");
    // scan continuous, then left unread until overrun
    rst();
    apb(1'b1, ADCSQ_IMSK_OFS, 32'h2);
    apb(1'b1, ADCSQ_CTRL_OFS, 32'h17);
    for (int i = 0; i < 4; i++) get_res(5'(1 - i % 2), 1'b0);
    repeat (40) @(posedge clk);
    apb(1'b0, ADCSQ_IRQS_OFS, 32'h0);
    chk("overrun", 32'h1, {31'h0, q[1]});
    chk("ovr_irq", 32'h1, {31'h0, irq});
    $display("test overrun done");
    // held conversion until the result is read
    for (int i = 0; i < 2; i++) begin
      rst();
      apb(1'b1, ADCSQ_CTRL_OFS, hcfg[i]);
      wait_x();
      x0 = xcnt;
      repeat (40) @(posedge clk);
      chk("held", x0, xcnt);
      chk("no_samp", 32'h0, {31'h0, samp});
      apb(1'b0, ADCSQ_IRQS_OFS, 32'h0);
      chk("no_ovr", 32'h0, {31'h0, q[1]});
      apb(1'b0, ADCSQ_RES_OFS, 32'h0);
      chk("old", {17'h0, hc1[i], 1'b0, hc1[i], 4'h5}, q);
      get_res(hc2[i], 1'b0);
      $display("test hold %0d done", i);
    end
    // injection during single channel continuous
    rst();
    apb(1'b1, ADCSQ_CTRL_OFS, 32'h45);
    get_res(5'd4, 1'b0);
    apb(1'b1, ADCSQ_CTRL_OFS, 32'h2641);
    poll(ADCSQ_IRQS_OFS, 2, 1'b1);
    apb(1'b0, ADCSQ_INJ_OFS, 32'h0);
    chk("inject", {17'h0, 5'd9, 1'b0, 5'd9, 4'h5}, q);
    get_res(5'd4, 1'b0);
    $display("test inject done");
    report_and_stop();
  end
endmodule  // testbench
`default_nettype wire
